// ===== design/rsc_channel_config.sv
// Two-channel remote sensor configuration, tracking and wheel test logic
//
// Overview of operation
// - Two channels, configs at 4A and 4B
// - Variant code picks frame length and rate
// - Codes 1xxx fall back; field resets 0000
// - Normal range: saturation steers base, delta speed
// - Narrow range: quarter-delta windows set speeds
// - Freeze bit low: base tracks in message
// - Freeze bit high: base stops in message
// - Start-bit period measured unless disabled
// - Fixed threshold latched, else adaptive thresholds
// - Slot control off when bit set
// - Blanking lasts 5ms or 10ms
// - Wheel filter (16+x) or (24+x) osc periods
// - Pass-through follows its enable bit
// - Averaging freezes base, averages delta in message
// - Test select codes force wheel output
// - Test level drives forced output
// - Test register at 48, resets zero
// - Supply and sync-pulse bits per channel
`timescale 1ns/10ps
`include "rsc_params.svh"
module rsc_channel_config #(
    parameter int BLANK_SHORT_CYCLES =
        `RSC_BLANK_SHORT_US * (`RSC_CLK_KHZ / 1000),
    parameter int BLANK_LONG_CYCLES =
        `RSC_BLANK_LONG_US * (`RSC_CLK_KHZ / 1000)
) (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_secondary_state_reset,
    input wire logic i_spi_clk,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_mosi,
    output logic o_spi_miso,
    output logic o_spi_miso_oe,
    output logic o_frame_dropped,
    input wire logic [1:0] i_rx_sat_pre_filt,
    input wire logic [1:0] i_below_base_quarter,
    input wire logic [1:0] i_above_top_quarter,
    input wire logic [1:0] i_blank_start,
    input wire logic [1:0] i_startbit_seen,
    input wire logic [1:0] i_frame_end,
    input wire logic [1:0] i_wheel_raw,
    output rsc_pkg::rsc_track_s [1:0] o_tracking,
    output logic [1:0] o_blanking,
    output logic [1:0][3:0] o_sensor_variant,
    output logic [1:0] o_rate_189k,
    output logic [1:0] o_ten_bit_frame,
    output logic [1:0] o_measure_startbit,
    output logic [1:0] o_adaptive_threshold,
    output logic [1:0] o_threshold_latch,
    output logic [1:0] o_slot_control_on,
    output logic [1:0] o_passthrough,
    output logic [1:0] o_channel_supply_on,
    output logic [1:0] o_channel_sync_pulse_on,
    output logic [1:0] o_wheel_speed_output
);
    import rsc_pkg::*;

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function automatic logic [3:0] eff_variant(input logic [3:0] code);
        eff_variant = code[3] ? `RSC_VARIANT_DEFAULT : code;
    endfunction

    // Least filter time rounds up to whole system clocks
    function automatic logic [5:0] filt_cycles(input rsc_cfg_s c);
        logic [3:0] v;
        int base;
        int n;
        v = eff_variant(c.sensor_variant_select);
        base = v[0] ? `RSC_FILT_BASE_189K : `RSC_FILT_BASE_125K;
        n = base + int'(c.wheel_pulse_filter_time);
        n = (n * `RSC_CLK_KHZ + `RSC_OSC_KHZ - 1) / `RSC_OSC_KHZ;
        filt_cycles = 6'(n);
    endfunction

    function automatic rsc_track_s track(input rsc_cfg_s c,
        input logic sat, input logic below, input logic above,
        input logic blank, input logic msg);
        rsc_track_e bspd;
        rsc_track_e dspd;
        rsc_track_s t;
        if (c.narrow_tracking_window) begin
            bspd = below ? TRK_FAST : TRK_SLOW;
            dspd = above ? TRK_FAST : TRK_SLOW;
        end else begin
            bspd = sat ? TRK_SLOW : TRK_FAST;
            dspd = sat ? TRK_FAST : TRK_OFF;
        end
        if (c.current_averaging_enable) begin
            t.base = (blank || msg) ? TRK_OFF : bspd;
            t.delta = blank ? TRK_OFF : (msg ? TRK_AVG : dspd);
        end else begin
            // base runs in blanking and message
            // freeze bit stops base in message
            t.base = (msg && !blank && c.freeze_tracking_in_frame)
                     ? TRK_OFF : bspd;
            t.delta = blank ? TRK_OFF : dspd;
        end
        track = t;
    endfunction

    function automatic logic [19:0] read_word(input logic [7:0] id,
        input rsc_core_s s);
        case (id)
            `RSC_ID_CFG0: read_word = {4'h0, s.cfg[0]};
            `RSC_ID_CFG1: read_word = {4'h0, s.cfg[1]};
            `RSC_ID_WHEEL_SPEED_TEST_REQUEST: read_word = {11'h000, s.test_sel, 1'b0,
                                           s.test_lvl};
            `RSC_ID_CHAN_CTRL: read_word = {16'h0000, s.supply[1],
                                            s.sync[1], s.supply[0],
                                            s.sync[0]};
            default: read_word = 20'h00000;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // State and buffer
    // ----------------------------------------------------------------
    rsc_core_s s_r;
    rsc_core_s s_nxt;
    rsc_frame_s rx_frame;
    rsc_frame_s drain_frame;
    logic push_valid;
    logic push_ready;
    logic drain_valid;
    logic drain_ready;
    logic drain_fire;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;

    assign cs_fall = s_r.cs_s[2] && !s_r.cs_s[1];
    assign cs_rise = !s_r.cs_s[2] && s_r.cs_s[1];
    assign sclk_rise = !s_r.sclk_s[2] && s_r.sclk_s[1] && !s_r.cs_s[1];
    assign sclk_fall = s_r.sclk_s[2] && !s_r.sclk_s[1] && !s_r.cs_s[1];
    assign rx_frame = s_r.rx_sh;
    assign push_valid = cs_rise && (s_r.bit_cnt == `RSC_FRAME_BITS);
    // Register updates wait while the state reset is held
    assign drain_ready = !i_secondary_state_reset;
    assign drain_fire = drain_valid && drain_ready;

    rsc_pair_buffer u_frame_buffer (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_valid(push_valid),
        .o_ready(push_ready),
        .i_data(rx_frame),
        .o_valid(drain_valid),
        .i_ready(drain_ready),
        .o_data(drain_frame)
    );

    always_comb begin
        s_nxt = s_r;
        s_nxt.sclk_s = {s_r.sclk_s[1:0], i_spi_clk};
        s_nxt.cs_s = {s_r.cs_s[1:0], i_spi_cs_n};
        s_nxt.mosi_s = {s_r.mosi_s[0], i_spi_mosi};
        s_nxt.wheel_m = i_wheel_raw;
        s_nxt.wheel_q = s_r.wheel_m;
        s_nxt.frame_drop = push_valid && !push_ready;
        s_nxt.thr_pulse = 2'b00;

        // ------------------------------------------------------------
        // Serial frame shifter, answer of the previous read
        // ------------------------------------------------------------
        if (cs_fall) begin
            s_nxt.bit_cnt = 6'h00;
            s_nxt.tx_sh = {s_r.rd_id, 4'h0, s_r.rd_data};
            s_nxt.miso = s_r.rd_id[7];
        end
        if (sclk_rise) begin
            s_nxt.rx_sh = {s_r.rx_sh[30:0], s_r.mosi_s[1]};
            if (s_r.bit_cnt != 6'h3f) begin
                s_nxt.bit_cnt = s_r.bit_cnt + 6'h01;
            end
        end
        if (sclk_fall) begin
            s_nxt.tx_sh = {s_r.tx_sh[30:0], 1'b0};
            s_nxt.miso = s_r.tx_sh[30];
        end

        // ------------------------------------------------------------
        // Register file
        // ------------------------------------------------------------
        if (drain_fire) begin
            s_nxt.rd_id = drain_frame.id;
            s_nxt.rd_data = read_word(drain_frame.id, s_r);
            if (drain_frame.wr) begin
                case (drain_frame.id)
                    `RSC_ID_CFG0: s_nxt.cfg[0] = drain_frame.data[15:0];
                    `RSC_ID_CFG1: s_nxt.cfg[1] = drain_frame.data[15:0];
                    `RSC_ID_WHEEL_SPEED_TEST_REQUEST: begin
                        s_nxt.test_sel = drain_frame.data[
                            `RSC_TEST_SEL_MSB:`RSC_TEST_SEL_LSB];
                        s_nxt.test_lvl =
                            drain_frame.data[`RSC_TEST_LVL_BIT];
                    end
                    `RSC_ID_CHAN_CTRL: begin
                        s_nxt.sync[0] =
                            drain_frame.data[`RSC_CTRL_SYNC0_BIT];
                        s_nxt.supply[0] =
                            drain_frame.data[`RSC_CTRL_SUPPLY0_BIT];
                        s_nxt.sync[1] =
                            drain_frame.data[`RSC_CTRL_SYNC1_BIT];
                        s_nxt.supply[1] =
                            drain_frame.data[`RSC_CTRL_SUPPLY1_BIT];
                    end
                    default: s_nxt.rd_data = 20'h00000;
                endcase
            end
        end

        for (int ch = 0; ch < 2; ch++) begin
            // latch threshold on the rising select bit
            s_nxt.thr_pulse[ch] =
                s_nxt.cfg[ch].static_threshold_select &&
                !s_r.cfg[ch].static_threshold_select;

            if (i_blank_start[ch]) begin
                s_nxt.blank_cnt[ch] =
                    s_r.cfg[ch].blanking_interval_select
                    ? 18'(BLANK_LONG_CYCLES) : 18'(BLANK_SHORT_CYCLES);
            end else if (s_r.blank_cnt[ch] != 18'h00000) begin
                s_nxt.blank_cnt[ch] = s_r.blank_cnt[ch] - 18'h00001;
            end

            // Message phase opens at the start bits
            if (i_blank_start[ch] || i_frame_end[ch]) begin
                s_nxt.in_msg[ch] = 1'b0;
            end else if (i_startbit_seen[ch]) begin
                s_nxt.in_msg[ch] = 1'b1;
            end

            // wheel level must hold for the filter time
            if (s_r.wheel_q[ch] == s_r.wheel_f[ch]) begin
                s_nxt.filt_cnt[ch] = 6'h00;
            end else if (s_r.filt_cnt[ch] + 6'h01 >=
                         filt_cycles(s_r.cfg[ch])) begin
                s_nxt.filt_cnt[ch] = 6'h00;
                s_nxt.wheel_f[ch] = s_r.wheel_q[ch];
            end else begin
                s_nxt.filt_cnt[ch] = s_r.filt_cnt[ch] + 6'h01;
            end
        end

        if (i_reset || i_secondary_state_reset) begin
            s_nxt.cfg[0] = `RSC_CFG_RESET;
            s_nxt.cfg[1] = `RSC_CFG_RESET;
            s_nxt.test_sel = `RSC_TEST_SEL_RESET;
            s_nxt.test_lvl = 1'b0;
            s_nxt.supply = 2'b00;
            s_nxt.sync = 2'b00;
            s_nxt.thr_pulse = 2'b00;
        end
        if (i_reset) begin
            s_nxt = '0;
            s_nxt.cfg[0] = `RSC_CFG_RESET;
            s_nxt.cfg[1] = `RSC_CFG_RESET;
            s_nxt.sclk_s = 3'b000;
            s_nxt.cs_s = 3'b111;
        end
    end

    always_ff @(posedge i_clock) begin
        s_r <= s_nxt;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_spi_miso = s_r.miso;
    assign o_spi_miso_oe = !s_r.cs_s[1];
    assign o_frame_dropped = s_r.frame_drop;

    always_comb begin
        for (int ch = 0; ch < 2; ch++) begin
            o_blanking[ch] = (s_r.blank_cnt[ch] != 18'h00000);
            o_tracking[ch] = track(s_r.cfg[ch], i_rx_sat_pre_filt[ch],
                i_below_base_quarter[ch], i_above_top_quarter[ch],
                o_blanking[ch], s_r.in_msg[ch]);
            // variant sets rate and frame length
            o_sensor_variant[ch] =
                eff_variant(s_r.cfg[ch].sensor_variant_select);
            o_rate_189k[ch] = o_sensor_variant[ch][0];
            o_ten_bit_frame[ch] = o_sensor_variant[ch][1];
            o_measure_startbit[ch] = !s_r.cfg[ch].startbit_timing_off;
            o_adaptive_threshold[ch] =
                !s_r.cfg[ch].static_threshold_select;
            o_threshold_latch[ch] = s_r.thr_pulse[ch];
            // slot control active while bit clear
            o_slot_control_on[ch] = !s_r.cfg[ch].slot_control_off;
            o_passthrough[ch] = s_r.cfg[ch].passthrough_enable;
            o_channel_supply_on[ch] = s_r.supply[ch];
            o_channel_sync_pulse_on[ch] = s_r.sync[ch];
        end
        // test codes force one wheel output
        // forced output follows the test level
        o_wheel_speed_output = s_r.wheel_f;
        if (s_r.test_sel == `RSC_TEST_SEL_WS1) begin
            o_wheel_speed_output[1] = s_r.test_lvl;
        end else if (s_r.test_sel == `RSC_TEST_SEL_WS0) begin
            o_wheel_speed_output[0] = s_r.test_lvl;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_variant_fall_back:
        assert property (@(posedge i_clock) disable iff (i_reset)
            s_r.cfg[1].sensor_variant_select[3] |->
            o_sensor_variant[1] == `RSC_VARIANT_DEFAULT)
        else $error("unusable variant code not replaced");

    a_test_forces_ws1:
        assert property (@(posedge i_clock) disable iff (i_reset)
            (s_r.test_sel == `RSC_TEST_SEL_WS1) |->
            (o_wheel_speed_output[1] == s_r.test_lvl &&
             o_wheel_speed_output[0] == s_r.wheel_f[0]))
        else $error("wheel output 1 not forced by test code");

    a_sat_tracking:
        assert property (@(posedge i_clock) disable iff (i_reset)
            (!s_r.cfg[0].narrow_tracking_window &&
             !s_r.cfg[0].current_averaging_enable && !o_blanking[0] &&
             !(s_r.cfg[0].freeze_tracking_in_frame && s_r.in_msg[0]) &&
             i_rx_sat_pre_filt[0]) |->
            (o_tracking[0].base == TRK_SLOW &&
             o_tracking[0].delta == TRK_FAST))
        else $error("saturation tracking speeds wrong");

    a_narrow_base_slow:
        assert property (@(posedge i_clock) disable iff (i_reset)
            (s_r.cfg[0].narrow_tracking_window &&
             !s_r.cfg[0].current_averaging_enable &&
             !s_r.cfg[0].freeze_tracking_in_frame &&
             !i_below_base_quarter[0]) |->
            o_tracking[0].base == TRK_SLOW)
        else $error("narrow range base speed wrong");

    a_freeze_in_msg:
        assert property (@(posedge i_clock) disable iff (i_reset)
            (s_r.cfg[0].freeze_tracking_in_frame &&
             !s_r.cfg[0].current_averaging_enable &&
             i_startbit_seen[0] && !i_blank_start[0] &&
             !i_frame_end[0] && !o_blanking[0] && !drain_fire) |=>
            (o_blanking[0] || o_tracking[0].base == TRK_OFF))
        else $error("base tracking not stopped in message");

    a_avg_delta_msg:
        assert property (@(posedge i_clock) disable iff (i_reset)
            (s_r.cfg[0].current_averaging_enable && s_r.in_msg[0] &&
             !o_blanking[0]) |->
            (o_tracking[0].delta == TRK_AVG &&
             o_tracking[0].base == TRK_OFF))
        else $error("averaging mode tracking wrong");

    a_blank_short_run:
        assert property (@(posedge i_clock) disable iff (i_reset)
            (i_blank_start[0] && !s_r.cfg[0].blanking_interval_select)
            |=> o_blanking[0] [*8])
        else $error("blanking ended too early");

    a_secondary_state_reset_cfg:
        assert property (@(posedge i_clock) disable iff (i_reset)
            i_secondary_state_reset |=>
            (s_r.cfg[1] == `RSC_CFG_RESET && s_r.test_sel == 7'h00 &&
             o_channel_supply_on == 2'b00))
        else $error("state reset left configuration set");

    a_supply_write:
        assert property (@(posedge i_clock) disable iff (i_reset)
            (drain_fire && drain_frame.wr &&
             drain_frame.id == `RSC_ID_CHAN_CTRL) |=>
            (o_channel_supply_on[1] == $past(drain_frame.data[3]) &&
             o_channel_sync_pulse_on[0] == $past(drain_frame.data[0])))
        else $error("supply control write not applied");

endmodule

// ===== design/rsc_pair_buffer.sv
// Two-entry frame buffer between frame receiver and register file
`timescale 1ns/10ps
module rsc_pair_buffer (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_valid,
    output logic o_ready,
    input rsc_pkg::rsc_frame_s i_data,
    output logic o_valid,
    input wire logic i_ready,
    output rsc_pkg::rsc_frame_s o_data
);
    import rsc_pkg::*;

    rsc_buf_s b_r;
    rsc_buf_s b_nxt;
    logic push;
    logic pop;

    assign o_ready = (b_r.count != 2'h2);
    assign o_valid = (b_r.count != 2'h0);
    assign o_data = b_r.slot[b_r.rd_ptr];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    always_comb begin
        b_nxt = b_r;
        if (push) begin
            b_nxt.slot[b_r.wr_ptr] = i_data;
            b_nxt.wr_ptr = ~b_r.wr_ptr;
        end
        if (pop) begin
            b_nxt.rd_ptr = ~b_r.rd_ptr;
        end
        case ({push, pop})
            2'b10: b_nxt.count = b_r.count + 2'h1;
            2'b01: b_nxt.count = b_r.count - 2'h1;
            default: b_nxt.count = b_r.count;
        endcase
        if (i_reset) begin
            b_nxt = '0;
        end
    end

    always_ff @(posedge i_clock) begin
        b_r <= b_nxt;
    end

    a_buf_bound_count:
        assert property (@(posedge i_clock) disable iff (i_reset)
            b_r.count <= 2'h2)
        else $error("buffer holds more than two entries");

    a_buf_full_stall:
        assert property (@(posedge i_clock) disable iff (i_reset)
            (b_r.count == 2'h2 && !i_ready) |=> (b_r.count == 2'h2))
        else $error("full buffer lost an entry while stalled");

endmodule

// ===== design/rsc_params.svh
// Register identifiers, field positions, reset values and timing counts
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH

// ----------------------------------------------------------------
// Register identifiers
// ----------------------------------------------------------------
`define RSC_ID_WHEEL_SPEED_TEST_REQUEST 8'h48
`define RSC_ID_CFG0 8'h4a
`define RSC_ID_CFG1 8'h4b
`define RSC_ID_CHAN_CTRL 8'h4e

// ----------------------------------------------------------------
// Frame layout and field positions
// ----------------------------------------------------------------
`define RSC_FRAME_BITS 6'h20
`define RSC_FRM_WR_BIT 23
`define RSC_TEST_SEL_MSB 8
`define RSC_TEST_SEL_LSB 2
`define RSC_TEST_LVL_BIT 0
`define RSC_CTRL_SYNC0_BIT 0
`define RSC_CTRL_SUPPLY0_BIT 1
`define RSC_CTRL_SYNC1_BIT 2
`define RSC_CTRL_SUPPLY1_BIT 3

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define RSC_CFG_RESET 16'h0080
`define RSC_TEST_SEL_RESET 7'h00
`define RSC_TEST_SEL_WS1 7'h59
`define RSC_TEST_SEL_WS0 7'h56
`define RSC_VARIANT_DEFAULT 4'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RSC_CLK_KHZ 25000
`define RSC_OSC_KHZ 16000
`define RSC_BLANK_SHORT_US 5000
`define RSC_BLANK_LONG_US 10000
`define RSC_FILT_BASE_189K 16
`define RSC_FILT_BASE_125K 24

`endif

// ===== design/rsc_pkg.sv
// Types shared by the remote sensor configuration block
package rsc_pkg;

    typedef struct packed {
        logic [7:0] id;
        logic wr;
        logic [2:0] spare;
        logic [19:0] data;
    } rsc_frame_s;

    typedef struct packed {
        logic narrow_tracking_window;
        logic freeze_tracking_in_frame;
        logic startbit_timing_off;
        logic static_threshold_select;
        logic slot_control_off;
        logic blanking_interval_select;
        logic [3:0] wheel_pulse_filter_time;
        logic passthrough_enable;
        logic current_averaging_enable;
        logic [3:0] sensor_variant_select;
    } rsc_cfg_s;

    typedef enum logic [1:0] {
        TRK_OFF = 2'b00,
        TRK_SLOW = 2'b01,
        TRK_FAST = 2'b10,
        TRK_AVG = 2'b11
    } rsc_track_e;

    typedef struct packed {
        rsc_track_e base;
        rsc_track_e delta;
    } rsc_track_s;

    typedef struct packed {
        rsc_frame_s [1:0] slot;
        logic wr_ptr;
        logic rd_ptr;
        logic [1:0] count;
    } rsc_buf_s;

    typedef struct packed {
        logic [2:0] sclk_s;
        logic [2:0] cs_s;
        logic [1:0] mosi_s;
        logic [1:0] wheel_m;
        logic [1:0] wheel_q;
        logic [5:0] bit_cnt;
        logic [31:0] rx_sh;
        logic [31:0] tx_sh;
        logic miso;
        logic frame_drop;
        logic [7:0] rd_id;
        logic [19:0] rd_data;
        rsc_cfg_s [1:0] cfg;
        logic [6:0] test_sel;
        logic test_lvl;
        logic [1:0] supply;
        logic [1:0] sync;
        logic [1:0] thr_pulse;
        logic [1:0][17:0] blank_cnt;
        logic [1:0] in_msg;
        logic [1:0][5:0] filt_cnt;
        logic [1:0] wheel_f;
    } rsc_core_s;

endpackage

// ===== sim/rsc_channel_config_tb.sv
// Self-checking bench for the remote sensor configuration block
`timescale 1ns/10ps
module rsc_channel_config_tb;
    import rsc_pkg::*;
    logic i_clock = 0, i_reset = 1, ssr = 0, sclk = 0, csn = 1, mosi = 0;
    logic [1:0] sat = 0, blw = 0, abv = 0, go = 0, wraw = 0, bs, sb, fe;
    logic [1:0] blank, r189, ten, meas, adapt, slot, pt, sup, syn, ws;
    logic [1:0][3:0] vr;
    rsc_track_s [1:0] trk;
    logic [31:0] rx;
    logic [15:0] d;
    logic [3:0] e;
    int n_errors = 0, comparisons = 0, cnt;
    initial forever #20 i_clock = ~i_clock;
    rsc_sensor_model SM (.i_clock(i_clock), .i_go(go), .o_blank_start(bs),
        .o_startbit_seen(sb), .o_frame_end(fe));
    rsc_channel_config #(.BLANK_SHORT_CYCLES(20), .BLANK_LONG_CYCLES(40))
    DUT (.i_clock(i_clock), .i_reset(i_reset), .i_secondary_state_reset(ssr),
        .i_spi_clk(sclk), .i_spi_cs_n(csn), .i_spi_mosi(mosi),
        .o_spi_miso(), .o_spi_miso_oe(), .o_frame_dropped(),
        .i_rx_sat_pre_filt(sat), .i_below_base_quarter(blw),
        .i_above_top_quarter(abv), .i_blank_start(bs),
        .i_startbit_seen(sb), .i_frame_end(fe), .i_wheel_raw(wraw),
        .o_tracking(trk), .o_blanking(blank), .o_sensor_variant(vr),
        .o_rate_189k(r189), .o_ten_bit_frame(ten),
        .o_measure_startbit(meas), .o_adaptive_threshold(adapt),
        .o_threshold_latch(), .o_slot_control_on(slot),
        .o_passthrough(pt), .o_channel_supply_on(sup),
        .o_channel_sync_pulse_on(syn), .o_wheel_speed_output(ws));
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // One 32-bit frame; sclk phases of four system clocks
    task automatic spi(logic [7:0] id, logic wr, logic [19:0] dd);
        logic [31:0] f;
        f = {id, wr, 3'h0, dd};
        @(negedge i_clock) csn = 0;
        for (int i = 31; i >= 0; i--) begin
            mosi = f[i];
            repeat (4) @(negedge i_clock);
            rx[i] = DUT.o_spi_miso & DUT.o_spi_miso_oe;
            sclk = 1;
            repeat (4) @(negedge i_clock);
            sclk = 0;
        end
        repeat (4) @(negedge i_clock);
        csn = 1;
        repeat (8) @(negedge i_clock);
        chk("oe", DUT.o_spi_miso_oe, 1'b0);
    endtask
    task automatic rd(logic [7:0] id, logic [19:0] exp);
        spi(id, 0, 0);
        spi(8'h00, 0, 0);
        chk("readback", rx[23:0], {4'h0, exp});
    endtask
    function automatic rsc_track_s xtr(logic n, s, b, a);
        xtr.base = n ? (b ? TRK_FAST : TRK_SLOW) : (s ? TRK_SLOW : TRK_FAST);
        xtr.delta = n ? (a ? TRK_FAST : TRK_SLOW) : (s ? TRK_FAST : TRK_OFF);
    endfunction
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge i_clock);
        n_errors++;
        give_verdict();
    end
    initial begin
        void'($urandom(90084));
        repeat (10) @(negedge i_clock);
        i_reset = 0;
        repeat (3) @(negedge i_clock);
        rd(8'h4a, 20'h00080);
        rd(8'h4b, 20'h00080);
        rd(8'h48, 20'h0);
        rd(8'h4e, 20'h0);
        rd(8'h00, 20'h0);
        chk("slot", slot, 2'b11);
        $display("reset test done");
        for (int v = 0; v < 16; v++) begin
            d = {$urandom} & 16'hfff0 | v;
            spi(8'h4a, 1, {4'h0, d});
            e = v[3] ? 4'h0 : v[3:0];
            chk("variant", vr[0], e);
            chk("rate", {ten[0], r189[0]}, e[1:0]);
            chk("meas", meas[0], !d[13]);
            chk("adapt", adapt[0], !d[12]);
            chk("slot", slot[0], !d[11]);
            chk("pass", pt[0], d[5]);
            spi(8'h4b, 1, {4'h0, ~d});
            chk("pass1", pt[1], !d[5]);
            rd(8'h4a, {4'h0, d});
        end
        $display("variant test done");
        for (int n = 0; n < 2; n++) begin
            spi(8'h4a, 1, {4'h0, n[0], 15'h0080});
            for (int k = 0; k < 8; k++) begin
                sat[0] = k[0];
                blw[0] = k[1];
                abv[0] = k[2];
                @(negedge i_clock);
                chk("track", trk[0], xtr(n[0], k[0], k[1], k[2]));
            end
        end
        $display("tracking test done");
        sat[0] = 1;
        for (int s = 0; s < 3; s++) begin
            spi(8'h4a, 1, {5'h0, s[0], 3'h0, s[0], 4'h2, 1'b0, s[1], 4'h0});
            go[0] = 1;
            @(negedge i_clock) go[0] = 0;
            repeat (2) @(negedge i_clock);
            chk("delta", trk[0].delta, TRK_OFF);
            chk("base", trk[0].base, s[1] ? TRK_OFF : TRK_SLOW);
            cnt = 2;
            repeat (67) @(negedge i_clock) cnt += blank[0];
            chk("msgb", trk[0].base, s ? TRK_OFF : TRK_SLOW);
            chk("msgd", trk[0].delta, s[1] ? TRK_AVG : TRK_FAST);
            repeat (33) @(negedge i_clock) cnt += blank[0];
            chk("blank", cnt, s[0] ? 40 : 20);
        end
        $display("blanking test done");
        wraw = 2'b11;
        for (int k = 0; k < 6; k++) begin
            d = k < 2 ? 16'h59 : (k < 4 ? 16'h56 : 16'h2a);
            spi(8'h48, 1, {11'h0, d[6:0], 1'b0, k[0]});
            e = {2'h0, d == 16'h59 ? k[0] : 1'b1, d == 16'h56 ? k[0] : 1'b1};
            chk("wheel", ws, e[1:0]);
        end
        $display("wheel test done");
        e = $urandom;
        spi(8'h4e, 1, {16'h0, e});
        chk("supply", sup, {e[3], e[1]});
        chk("sync", syn, {e[2], e[0]});
        ssr = 1;
        repeat (2) @(negedge i_clock);
        ssr = 0;
        rd(8'h4a, 20'h00080);
        rd(8'h4e, 20'h0);
        $display("secondary reset test done");
        give_verdict();
    end
endmodule

// ===== sim/rsc_sensor_model.sv
// Behavioural far-side sensor: blanking, start bit and frame end pulses
`timescale 1ns/10ps
module rsc_sensor_model (
    input wire logic i_clock,
    input wire logic [1:0] i_go,
    output logic [1:0] o_blank_start = '0,
    output logic [1:0] o_startbit_seen = '0,
    output logic [1:0] o_frame_end = '0
);
    logic [1:0][7:0] t = '0;
    always @(posedge i_clock) begin
        for (int c = 0; c < 2; c++) begin
            o_blank_start[c] <= i_go[c];
            t[c] <= i_go[c] ? 8'h01 : (t[c] != 0 ? t[c] + 8'h01 : 8'h00);
            o_startbit_seen[c] <= (t[c] == 8'h40);
            o_frame_end[c] <= (t[c] == 8'h60);
        end
    end
endmodule
